// ---- core/adc_config_regs.sv ----
// What this block does
// [R01] channel a selector low nibble, gated by enable
// [R02] 0000 normal, 0001 zeros, 0010 ones
// [R03] 0011 alternates 2aaa and 1555 per sample
// [R04] 0100 ramp up one per sample clock
// [R05] ramp wraps from 16383 to zero
// [R06] 0101 outputs shared user pattern
// [R07] 0110 outputs fixed alignment word 2aaa
// [R08] 1000 outputs pseudo-random sequence per sample
// [R09] 1001 repeats eight-point sine table
// [R10] channel b selector upper nibble, same codes
// [R11] user pattern from two byte registers
// [R12] controller picks low-speed code by rate
// [R13] bits 6 and 5 power channels down
// [R14] bit 3 puts both converters in standby
// [R15] bit 2 gives whole-chip power-down
// [R16] bit 0 selects power-down pin role
// [R17] swing register applies listed nibble pairs
// [R18] divider field divides by 1,1,2,4
// [R19] controller sets high-if bits for high input
// [R20] chopper register bit 1 disables chopper
// [R21] controller sets both dither fields together
// [R22] controller writes perf bit after reset
// [R23] reference-input bit 0 powers down buffer
// [R24] reference-input bit 7 disables clock filter
// [R25] reserved bits zero, registers reset zero
// [R26] global pattern enable is a separate bit
`include "cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_config_regs #(
   parameter int DATA_W = 14
) (
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst,
   input  wire logic                 i_wr_en,
   input  wire logic [13:0]          i_wr_addr,
   input  wire logic [7:0]           i_wr_data,
   input  wire logic [13:0]          i_rd_addr,
   input  wire logic                 i_pattern_out_en,
   input  wire logic                 i_powerdown_pin,
   input  wire logic [13:0]          i_chan_a_sample,
   input  wire logic [13:0]          i_chan_b_sample,
   output logic [7:0]                o_rd_data,
   output cfg_pkg::sample_pair_t     o_sample,
   output cfg_pkg::power_state_t     o_power,
   output logic [7:0]                o_swing_code,
   output logic                      o_swing_valid,
   output logic [2:0]                o_clk_div_ratio,
   output logic [3:0]                o_high_if_mode,
   output logic                      o_chan_a_chopper_off,
   output logic                      o_chan_b_chopper_off,
   output logic                      o_chan_a_dither_off,
   output logic                      o_chan_b_dither_off,
   output logic                      o_chan_a_perf_mode,
   output logic                      o_chan_b_perf_mode,
   output logic                      o_ref_buffer_powerdown,
   output logic                      o_clock_filter_off,
   output logic [1:0]                o_slow_rate
);

   initial begin
      if (DATA_W != 14) begin
         $error("adc_config_regs supports only a 14-bit sample word");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   localparam int NREG = 18;
   localparam logic [13:0] ADDRS [NREG] = '{
      `ADDR_CHAN_A_PAT, `ADDR_CHAN_B_PAT, `ADDR_USER_PAT_HI, `ADDR_USER_PAT_LO,
      `ADDR_SLOW_RATE, `ADDR_POWER_CTRL, `ADDR_OUT_SWING, `ADDR_CLK_DIV,
      `ADDR_HIGH_IF_B0, `ADDR_CHAN_A_CHOP, `ADDR_CHAN_A_DITH, `ADDR_CHAN_A_PERF,
      `ADDR_HIGH_IF_B1, `ADDR_CHAN_B_CHOP, `ADDR_CHAN_B_DITH, `ADDR_CHAN_B_PERF,
      `ADDR_HIGH_IF_UP, `ADDR_CLKF_REFBUF};
   localparam logic [7:0] MASKS [NREG] = '{
      `MASK_CHAN_A_PAT, `MASK_CHAN_B_PAT, `MASK_FULL, `MASK_USER_PAT_LO,
      `MASK_SLOW_RATE, `MASK_POWER_CTRL, `MASK_FULL, `MASK_CLK_DIV,
      `MASK_BIT1, `MASK_BIT1, `MASK_DITH_EXT, `MASK_BIT3,
      `MASK_BIT1, `MASK_BIT1, `MASK_DITH_EXT, `MASK_BIT3,
      `MASK_CLK_DIV, `MASK_CLKF_REFBUF};

   logic [7:0] regs_ff [NREG];
   logic [7:0] rd_mux;

   // reserved bits never store; everything resets to zero
   generate
      for (genvar g = 0; g < NREG; g++) begin : g_reg
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               regs_ff[g] <= `REG_RESET; // R25
            end else if (i_wr_en && i_wr_addr == ADDRS[g]) begin
               regs_ff[g] <= i_wr_data & MASKS[g];
            end
         end
      end
   endgenerate

   // read-back mux; unmapped addresses read zero
   always_comb begin
      rd_mux = 8'h00;
      for (int k = 0; k < NREG; k++) begin
         if (i_rd_addr == ADDRS[k]) begin
            rd_mux = regs_ff[k];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field decode

   wire [3:0]  sel_a    = regs_ff[0][3:0];                   // R01
   wire [3:0]  sel_b    = regs_ff[1][7:4];                   // R10
   wire [13:0] user_pat = {regs_ff[2], regs_ff[3][7:2]};     // R11
   wire [7:0]  pwr      = regs_ff[5];

   // pin crosses in from outside: two flops before use
   logic pin_meta_ff;
   logic pin_sync_ff;
   logic pat_en_meta_ff;
   logic pat_en_ff;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pin_meta_ff    <= 1'b0;
         pin_sync_ff    <= 1'b0;
         pat_en_meta_ff <= 1'b0;
         pat_en_ff      <= 1'b0;
      end else begin
         pin_meta_ff    <= i_powerdown_pin;
         pin_sync_ff    <= pin_meta_ff;
         pat_en_meta_ff <= i_pattern_out_en;
         pat_en_ff      <= pat_en_meta_ff;
      end
   end

   // pin role: clear means pin forces global power-down, set means standby
   wire pin_to_global  = pin_sync_ff & ~pwr[`PWR_PIN_ROLE_BIT]; // R16
   wire pin_to_standby = pin_sync_ff & pwr[`PWR_PIN_ROLE_BIT];  // R16
   cfg_pkg::power_state_t nxt_power;
   assign nxt_power.chan_a_powerdown     = pwr[`PWR_CHAN_A_BIT];               // R13
   assign nxt_power.chan_b_powerdown     = pwr[`PWR_CHAN_B_BIT];               // R13
   assign nxt_power.standby              = pwr[`PWR_STANDBY_BIT] | pin_to_standby; // R14
   assign nxt_power.whole_chip_powerdown = pwr[`PWR_GLOBAL_BIT] | pin_to_global;   // R15

   // only the listed swing pairs are applied; others fall back to default
   wire [7:0] swing = regs_ff[6];
   wire swing_ok = (swing == 8'h00) || (swing == 8'hd9) || (swing == 8'hea) ||
                   (swing == 8'hfd) || (swing == 8'hce); // R17

   // divider: 00 and 01 divide by one
   wire [1:0] div_code = regs_ff[7][7:6];
   wire [2:0] nxt_div  = (div_code == 2'b11) ? 3'd4 :
                         (div_code == 2'b10) ? 3'd2 : 3'd1; // R18

   ////////////////////////////////////////////////////////////////////////////////
   // pattern sources, shared by both channels

   logic [13:0] ramp_ff;
   logic        toggle_ff;
   logic [2:0]  sine_idx_ff;
   logic [22:0] prbs_ff;

   // ramp is compared against PAT_RAMP_MAX and reloads zero after it
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ramp_ff     <= 14'h0000;
         toggle_ff   <= 1'b0;
         sine_idx_ff <= 3'h0;
         prbs_ff     <= `PRBS_SEED;
      end else begin
         ramp_ff     <= (ramp_ff == `PAT_RAMP_MAX) ? 14'h0000 : ramp_ff + 14'h0001; // R05
         toggle_ff   <= ~toggle_ff;          // R03
         sine_idx_ff <= sine_idx_ff + 3'h1;  // R09
         prbs_ff     <= {prbs_ff[21:0], prbs_ff[22] ^ prbs_ff[17]}; // R08
      end
   end

   function automatic logic [13:0] sine_word(input logic [2:0] idx);
      case (idx)
         3'd0: sine_word = 14'd0;
         3'd1: sine_word = 14'd2399;
         3'd2: sine_word = 14'd8192;
         3'd3: sine_word = 14'd13984;
         3'd4: sine_word = 14'd16383;
         3'd5: sine_word = 14'd13984;
         3'd6: sine_word = 14'd8192;
         default: sine_word = 14'd2399;
      endcase
   endfunction

   // per-channel selection; invalid codes pass normal data
   function automatic logic [13:0] pick(input logic [3:0] sel, input logic en,
                                        input logic [13:0] norm);
      if (!en) begin
         pick = norm; // R26
      end else begin
         case (sel)
            cfg_pkg::PAT_ZEROS:  pick = 14'h0000;       // R02
            cfg_pkg::PAT_ONES:   pick = `PAT_ALL_ONES;  // R02
            cfg_pkg::PAT_TOGGLE: pick = toggle_ff ? `PAT_TOGGLE_B : `PAT_TOGGLE_A; // R03
            cfg_pkg::PAT_RAMP:   pick = ramp_ff;        // R04
            cfg_pkg::PAT_USER:   pick = user_pat;       // R06
            cfg_pkg::PAT_ALIGN:  pick = `PAT_ALIGN;     // R07
            cfg_pkg::PAT_PRBS:   pick = prbs_ff[13:0];  // R08
            cfg_pkg::PAT_SINE:   pick = sine_word(sine_idx_ff); // R09
            default:             pick = norm;           // R02
         endcase
      end
   endfunction

   wire [13:0] nxt_a = pick(sel_a, pat_en_ff, i_chan_a_sample); // R01
   wire [13:0] nxt_b = pick(sel_b, pat_en_ff, i_chan_b_sample); // R10

   ////////////////////////////////////////////////////////////////////////////////
   // registered outputs

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data              <= 8'h00;
         o_sample               <= '0;
         o_power                <= '0;
         o_swing_code           <= 8'h00;
         o_swing_valid          <= 1'b1;
         o_clk_div_ratio        <= 3'd1;
         o_high_if_mode         <= 4'h0;
         o_chan_a_chopper_off   <= 1'b0;
         o_chan_b_chopper_off   <= 1'b0;
         o_chan_a_dither_off    <= 1'b0;
         o_chan_b_dither_off    <= 1'b0;
         o_chan_a_perf_mode     <= 1'b0;
         o_chan_b_perf_mode     <= 1'b0;
         o_ref_buffer_powerdown <= 1'b0;
         o_clock_filter_off     <= 1'b0;
         o_slow_rate            <= 2'b00;
      end else begin
         o_rd_data              <= rd_mux;
         o_sample               <= {nxt_a, nxt_b};
         o_power                <= nxt_power;
         o_swing_code           <= swing_ok ? swing : 8'h00; // R17
         o_swing_valid          <= swing_ok;
         o_clk_div_ratio        <= nxt_div;
         o_high_if_mode         <= {regs_ff[16][7:6], regs_ff[12][1], regs_ff[8][1]};
         o_chan_a_chopper_off   <= regs_ff[9][1];  // R20
         o_chan_b_chopper_off   <= regs_ff[13][1]; // R20
         // dither is off only when both extended bits are set
         o_chan_a_dither_off    <= &{regs_ff[10][5], regs_ff[10][3]};
         o_chan_b_dither_off    <= &{regs_ff[14][5], regs_ff[14][3]};
         o_chan_a_perf_mode     <= regs_ff[11][3];
         o_chan_b_perf_mode     <= regs_ff[15][3];
         o_ref_buffer_powerdown <= regs_ff[17][0]; // R23
         o_clock_filter_off     <= regs_ff[17][7]; // R24
         o_slow_rate            <= regs_ff[4][1:0];
      end
   end

endmodule

`default_nettype wire

// ---- core/cfg_defs.svh ----
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH
// register addresses (14-bit serial address space)
`define ADDR_CHAN_A_PAT    14'h000a
`define ADDR_CHAN_B_PAT    14'h000b
`define ADDR_USER_PAT_HI   14'h000e
`define ADDR_USER_PAT_LO   14'h000f
`define ADDR_SLOW_RATE     14'h0013
`define ADDR_POWER_CTRL    14'h0015
`define ADDR_OUT_SWING     14'h0025
`define ADDR_CLK_DIV       14'h0027
`define ADDR_HIGH_IF_B0    14'h041d
`define ADDR_CHAN_A_CHOP   14'h0422
`define ADDR_CHAN_A_DITH   14'h0434
`define ADDR_CHAN_A_PERF   14'h0439
`define ADDR_HIGH_IF_B1    14'h051d
`define ADDR_CHAN_B_CHOP   14'h0522
`define ADDR_CHAN_B_DITH   14'h0534
`define ADDR_CHAN_B_PERF   14'h0539
`define ADDR_HIGH_IF_UP    14'h0608
`define ADDR_CLKF_REFBUF   14'h070a
// writable-bit masks; reserved bits are held at zero
`define MASK_CHAN_A_PAT    8'h0f
`define MASK_CHAN_B_PAT    8'hf0
`define MASK_FULL          8'hff
`define MASK_USER_PAT_LO   8'hfc
`define MASK_SLOW_RATE     8'h03
`define MASK_POWER_CTRL    8'h6d
`define MASK_CLK_DIV       8'hc0
`define MASK_BIT1          8'h02
`define MASK_DITH_EXT      8'h28
`define MASK_BIT3          8'h08
`define MASK_CLKF_REFBUF   8'h81
`define REG_RESET          8'h00
// power control bit positions
`define PWR_CHAN_A_BIT     6
`define PWR_CHAN_B_BIT     5
`define PWR_STANDBY_BIT    3
`define PWR_GLOBAL_BIT     2
`define PWR_PIN_ROLE_BIT   0
// pattern words
`define PAT_ALL_ONES       14'h3fff
`define PAT_TOGGLE_A       14'h2aaa
`define PAT_TOGGLE_B       14'h1555
`define PAT_ALIGN          14'h2aaa
`define PAT_RAMP_MAX       14'h3fff
`define PRBS_SEED          23'h7fffff
`endif

// ---- core/cfg_pkg.sv ----
package cfg_pkg;
   typedef enum logic [3:0] {
      PAT_NORMAL = 4'b0000,
      PAT_ZEROS  = 4'b0001,
      PAT_ONES   = 4'b0010,
      PAT_TOGGLE = 4'b0011,
      PAT_RAMP   = 4'b0100,
      PAT_USER   = 4'b0101,
      PAT_ALIGN  = 4'b0110,
      PAT_PRBS   = 4'b1000,
      PAT_SINE   = 4'b1001
   } pat_sel_t;

   typedef struct packed {
      logic chan_a_powerdown;
      logic chan_b_powerdown;
      logic standby;
      logic whole_chip_powerdown;
   } power_state_t;

   typedef struct packed {
      logic [13:0] chan_a;
      logic [13:0] chan_b;
   } sample_pair_t;
endpackage

// ---- bench/adc_sample_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_sample_source (
   input  wire logic        i_mclk,
   output logic [13:0]      o_chan_a,
   output logic [13:0]      o_chan_b
);
   // conversion words move every cycle, so a stuck or late data path shows
   initial begin
      o_chan_a = 14'h0123;
      o_chan_b = 14'h3210;
   end
   // updated on the edge itself so the bench never races the new word
   always @(posedge i_mclk) begin
      o_chan_a <= o_chan_a + 14'h0007;
      o_chan_b <= o_chan_b ^ 14'h2b4d; // flips many bits, not a plain count
   end
endmodule
`default_nettype wire

// ---- bench/adc_config_regs_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs_asserts (
   input wire logic                  i_mclk,
   input wire logic                  i_rst,
   input wire logic                  i_wr_en,
   input wire logic [13:0]           i_wr_addr,
   input wire logic [7:0]            i_wr_data,
   input wire logic [13:0]           i_rd_addr,
   input wire logic                  i_pattern_out_en,
   input wire logic                  i_powerdown_pin,
   input wire logic [13:0]           i_chan_a_sample,
   input wire logic [7:0]            o_rd_data,
   input wire cfg_pkg::sample_pair_t o_sample,
   input wire cfg_pkg::power_state_t o_power,
   input wire logic                  o_swing_valid,
   input wire logic [2:0]            o_clk_div_ratio,
   input wire logic                  o_chan_a_chopper_off,
   input wire logic                  o_chan_a_dither_off,
   input wire logic                  o_ref_buffer_powerdown,
   input wire logic                  o_clock_filter_off
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////
   // register side: write then read back, masked
   rd_back_a: assert property (
      i_wr_en && i_wr_addr == 14'h0015 && i_rd_addr == 14'h0015
      ##1 !i_wr_en && i_rd_addr == 14'h0015
      |=> o_rd_data == ($past(i_wr_data, 2) & 8'h6d)) else $error("power readback wrong");
   // decoded outputs follow the field two edges after the write
   chop_off_a: assert property (i_wr_en && i_wr_addr == 14'h0422
      |-> ##2 o_chan_a_chopper_off == $past(i_wr_data[1], 2)) else $error("chopper wrong");
   dither_off_a: assert property (i_wr_en && i_wr_addr == 14'h0434
      |-> ##2 o_chan_a_dither_off == ($past(i_wr_data[5], 2) && $past(i_wr_data[3], 2)))
      else $error("dither wrong");
   ref_buf_a: assert property (i_wr_en && i_wr_addr == 14'h070a
      |-> ##2 {o_clock_filter_off, o_ref_buffer_powerdown}
      == {$past(i_wr_data[7], 2), $past(i_wr_data[0], 2)}) else $error("ref reg wrong");
   clk_div_a: assert property (i_wr_en && i_wr_addr == 14'h0027
      |-> ##2 o_clk_div_ratio == ($past(i_wr_data[7], 2)
      ? ($past(i_wr_data[6], 2) ? 3'h4 : 3'h2) : 3'h1)) else $error("divider wrong");
   swing_code_a: assert property (i_wr_en && i_wr_addr == 14'h0025
      |-> ##2 o_swing_valid == ($past(i_wr_data, 2) inside {8'h00, 8'hd9, 8'hea, 8'hfd,
      8'hce})) else $error("swing validity wrong");
   // pattern gate off: data is the previous input; sync delay is covered by four
   normal_data_a: assert property (
      (!i_pattern_out_en && o_power == 4'h0) [*4]
      |-> o_sample.chan_a == $past(i_chan_a_sample)) else $error("normal data wrong");
   pin_power_a: assert property (i_powerdown_pin [*4]
      |-> o_power.whole_chip_powerdown || o_power.standby) else $error("pin ignored");
   pat_on_c: cover property (i_pattern_out_en [*4]);
   standby_c: cover property (o_power.standby && i_powerdown_pin);
   bad_swing_c: cover property (!o_swing_valid);
endmodule
bind adc_config_regs adc_config_regs_asserts chk (.i_mclk, .i_rst, .i_wr_en, .i_wr_addr,
   .i_wr_data, .i_rd_addr, .i_pattern_out_en, .i_powerdown_pin, .i_chan_a_sample, .o_rd_data,
   .o_sample, .o_power, .o_swing_valid, .o_clk_div_ratio, .o_chan_a_chopper_off,
   .o_chan_a_dither_off, .o_ref_buffer_powerdown, .o_clock_filter_off);
`default_nettype wire

// ---- bench/adc_config_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs_tb;
   logic                  i_mclk = 1'b0;
   logic                  i_rst = 1'b1;
   logic                  i_wr_en = 1'b0;
   logic [13:0]           i_wr_addr = 14'h0000;
   logic [7:0]            i_wr_data = 8'h00;
   logic [13:0]           i_rd_addr = 14'h0000;
   logic                  i_pattern_out_en = 1'b0;
   logic                  i_powerdown_pin = 1'b0;
   logic [13:0]           i_chan_a_sample, i_chan_b_sample, p;
   logic [7:0]            o_rd_data, o_swing_code;
   cfg_pkg::sample_pair_t o_sample;
   cfg_pkg::power_state_t o_power;
   logic                  o_swing_valid, o_chan_a_chopper_off, o_chan_b_chopper_off;
   logic                  o_chan_a_dither_off, o_chan_b_dither_off, o_chan_a_perf_mode;
   logic                  o_chan_b_perf_mode, o_ref_buffer_powerdown, o_clock_filter_off;
   logic [2:0]            o_clk_div_ratio;
   logic [3:0]            o_high_if_mode;
   logic [1:0]            o_slow_rate;
   int                    fail_count = 0;
   int                    compares = 0;
   localparam logic [13:0] ADR [10] = '{14'h000a, 14'h000b, 14'h000f, 14'h0013, 14'h0015,
      14'h0027, 14'h0434, 14'h0439, 14'h0608, 14'h070a};
   localparam logic [7:0] MSK [10] = '{8'h0f, 8'hf0, 8'hfc, 8'h03, 8'h6d, 8'hc0, 8'h28,
      8'h08, 8'hc0, 8'h81};
   // sine points 0, 2399, 8192, 13984, 16383 and back down
   localparam logic [13:0] SIN [8] = '{14'h0000, 14'h095f, 14'h2000, 14'h36a0, 14'h3fff,
      14'h36a0, 14'h2000, 14'h095f};
   ////////////////////////////////////////////////////////////////////////
   adc_config_regs uut (.i_mclk, .i_rst, .i_wr_en, .i_wr_addr, .i_wr_data, .i_rd_addr,
      .i_pattern_out_en, .i_powerdown_pin, .i_chan_a_sample, .i_chan_b_sample, .o_rd_data,
      .o_sample, .o_power, .o_swing_code, .o_swing_valid, .o_clk_div_ratio, .o_high_if_mode,
      .o_chan_a_chopper_off, .o_chan_b_chopper_off, .o_chan_a_dither_off,
      .o_chan_b_dither_off, .o_chan_a_perf_mode, .o_chan_b_perf_mode,
      .o_ref_buffer_powerdown, .o_clock_filter_off, .o_slow_rate);
   adc_sample_source src (.i_mclk, .o_chan_a(i_chan_a_sample), .o_chan_b(i_chan_b_sample));
   always #10 i_mclk = ~i_mclk;
   ////////////////////////////////////////////////////////////////////////
   // inputs move 1 ns after the edge so the design never races the bench
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      i_wr_addr = a;
      i_wr_data = d;
      i_wr_en = 1'b1;
      cyc(1);
      i_wr_en = 1'b0;
      // idle edge so a following write never raises the strobe in this step
      cyc(1);
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input logic [13:0] a, input logic [7:0] e);
      i_rd_addr = a;
      cyc(1);
      chk("rd_data", e, o_rd_data);
   endtask
   task automatic sel(input logic [3:0] c);
      wr(14'h000a, {4'h0, c});
      wr(14'h000b, {c, 4'h0});
      cyc(3);
   endtask
   task automatic complete_run();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // reserved bits must read back zero; an unmapped address keeps nothing
   task automatic t_regs();
      for (int i = 0; i < 10; i++) begin
         rdchk(ADR[i], 8'h00);
         wr(ADR[i], 8'hff);
         rdchk(ADR[i], MSK[i]);
      end
      wr(14'h0000, 8'hff);
      rdchk(14'h0000, 8'h00);
      wr(14'h0013, 8'h02);
      rdchk(14'h0013, 8'h02);
      chk("slow_rate", 2'b10, o_slow_rate);
   endtask
   task automatic t_pat();
      logic [3:0]  c [4] = '{4'h1, 4'h2, 4'h5, 4'h6};
      logic [13:0] e [4] = '{14'h0000, 14'h3fff, {8'ha5, 6'h0f}, 14'h2aaa};
      int          n;
      wr(14'h000e, 8'ha5);
      wr(14'h000f, 8'h3c);
      i_pattern_out_en = 1'b1;
      for (int i = 0; i < 4; i++) begin
         sel(c[i]);
         chk("chan_a", e[i], o_sample.chan_a);
         chk("chan_b", e[i], o_sample.chan_b);
      end
      // code 0 and an unlisted code both pass conversion data through
      for (int i = 0; i < 2; i++) begin
         sel(i[0] ? 4'h7 : 4'h0);
         p = i_chan_a_sample;
         cyc(1);
         chk("normal", p, o_sample.chan_a);
      end
      sel(4'h1);
      i_pattern_out_en = 1'b0;
      cyc(4);
      p = i_chan_a_sample;
      cyc(1);
      chk("gated", p, o_sample.chan_a);
      i_pattern_out_en = 1'b1;
      sel(4'h3);
      p = o_sample.chan_a;
      chk("toggle_word", 1'b1, p == 14'h2aaa || p == 14'h1555);
      cyc(1);
      chk("toggle_next", p ^ 14'h3fff, o_sample.chan_a);
      sel(4'h8);
      p = o_sample.chan_a;
      cyc(1);
      chk("prbs_step", 1'b1, p !== o_sample.chan_a);
      sel(4'h4);
      for (n = 0; n < 16400 && o_sample.chan_a !== 14'h3fff; n++) cyc(1);
      if (n == 16400) begin
         fail_count++;
         complete_run();
      end
      cyc(1);
      chk("ramp_wrap", 14'h0000, o_sample.chan_a);
      cyc(1);
      chk("ramp_step", 14'h0001, o_sample.chan_b);
      sel(4'h9);
      for (n = 0; n < 16 && o_sample.chan_a !== 14'h0000; n++) cyc(1);
      if (n == 16) begin
         fail_count++;
         complete_run();
      end
      for (int k = 1; k < 8; k++) begin
         cyc(1);
         chk("sine", SIN[k], o_sample.chan_a);
      end
      i_pattern_out_en = 1'b0;
   endtask
   task automatic t_pwr();
      logic [7:0] d [3] = '{8'h60, 8'h08, 8'h04};
      logic [3:0] e [3] = '{4'b1100, 4'b0010, 4'b0001};
      i_rd_addr = 14'h0015;
      for (int i = 0; i < 3; i++) begin
         wr(14'h0015, d[i]);
         cyc(2);
         chk("power", e[i], o_power);
      end
      wr(14'h0015, 8'h00);
      i_powerdown_pin = 1'b1;
      cyc(4);
      chk("pin_global", 4'b0001, o_power);
      wr(14'h0015, 8'h01);
      cyc(2);
      chk("pin_standby", 4'b0010, o_power);
      i_powerdown_pin = 1'b0;
      cyc(4);
      chk("pin_low", 4'b0000, o_power);
   endtask
   task automatic t_misc();
      logic [2:0] r [4] = '{3'h1, 3'h1, 3'h2, 3'h4};
      wr(14'h0025, 8'hd9);
      cyc(2);
      chk("swing", 9'h1d9, {o_swing_valid, o_swing_code});
      wr(14'h0025, 8'h12);
      cyc(2);
      chk("swing_bad", 9'h000, {o_swing_valid, o_swing_code});
      for (int i = 0; i < 4; i++) begin
         wr(14'h0027, {i[1:0], 6'h00});
         cyc(2);
         chk("clk_div", r[i], o_clk_div_ratio);
      end
      wr(14'h041d, 8'h02);
      wr(14'h051d, 8'h02);
      wr(14'h0608, 8'hc0);
      wr(14'h0422, 8'h02);
      wr(14'h0522, 8'h02);
      wr(14'h0434, 8'h20);
      cyc(2);
      chk("high_if", 4'hf, o_high_if_mode);
      chk("chop", 2'b11, {o_chan_a_chopper_off, o_chan_b_chopper_off});
      chk("dither_half", 1'b0, o_chan_a_dither_off);
      wr(14'h0434, 8'h28);
      wr(14'h0534, 8'h28);
      wr(14'h0439, 8'h08);
      wr(14'h0539, 8'h08);
      wr(14'h070a, 8'h81);
      cyc(2);
      chk("dither", 2'b11, {o_chan_a_dither_off, o_chan_b_dither_off});
      chk("perf", 2'b11, {o_chan_a_perf_mode, o_chan_b_perf_mode});
      chk("ref", 2'b11, {o_clock_filter_off, o_ref_buffer_powerdown});
   endtask
   // a reset in mid-run must clear what was written
   task automatic t_reset();
      wr(14'h0015, 8'h60);
      i_rst = 1'b1;
      cyc(2);
      i_rst = 1'b0;
      rdchk(14'h0015, 8'h00);
      chk("power_rst", 4'h0, o_power);
   endtask
   initial begin
      repeat (8) @(posedge i_mclk);
      #1;
      i_rst = 1'b0;
      t_regs();
      t_pat();
      t_pwr();
      t_misc();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire
